// *** pkg/vic_params.svh ***
// Purpose: named constants for the interrupt controller host
// Assumes: 125 MHz core clock
// Notes: times in ns, cycle counts derived from them
//
// Summary of operation
// - single controller: slave program pin held high
// - host gives one acknowledge, then two more
// - end of service command clears service bit
// - host initializes with two or three words
// - request held until first acknowledge received
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

`define VIC_PERIOD_NS 8
`define VIC_CYC_MIN(ns) (((ns) + `VIC_PERIOD_NS - 1) / `VIC_PERIOD_NS)
`define VIC_T_SETUP_NS 50
`define VIC_T_WR_NS 400
`define VIC_T_RD_NS 420
`define VIC_T_HOLD_NS 40
`define VIC_T_GAP_NS 200
`define VIC_CYC_SETUP `VIC_CYC_MIN(`VIC_T_SETUP_NS)
`define VIC_CYC_WR `VIC_CYC_MIN(`VIC_T_WR_NS)
`define VIC_CYC_RD `VIC_CYC_MIN(`VIC_T_RD_NS)
`define VIC_CYC_HOLD `VIC_CYC_MIN(`VIC_T_HOLD_NS)
`define VIC_CYC_GAP `VIC_CYC_MIN(`VIC_T_GAP_NS)

`define VIC_OFF_CTRL 12'h000
`define VIC_OFF_CMD 12'h004
`define VIC_OFF_INIT 12'h008
`define VIC_OFF_RESULT 12'h00c
`define VIC_OFF_STATUS 12'h010
`define VIC_OFF_MASK 12'h014
`define VIC_OFF_REQ 12'h018
`define VIC_OFF_STATE 12'h01c

`define VIC_CTRL_RESET 2'h3
`define VIC_CTRL_AUTO_ACK 0
`define VIC_CTRL_SLAVE_PROG 1
`define VIC_ST_CMD_DONE 0
`define VIC_ST_VEC_DONE 1
`define VIC_ST_BAD_OP 2
`define VIC_CALL_OPCODE 8'hcd
`define VIC_INIT1_FLAG 8'h10
`define VIC_WORD_SEL_BITS 8'h18
`define VIC_ACK_BYTES 2'h3
`define VIC_INIT_LONG 2'h3
`define VIC_INIT_SHORT 2'h2

`endif

// *** pkg/vic_pkg.sv ***
// Purpose: types shared by the controller host files
// Assumes: vic_params.svh for numeric constants
// Notes: command word overlays the apb write data
package vic_pkg;

    typedef enum logic [2:0] {
        VIC_OP_WR0,
        VIC_OP_WR1,
        VIC_OP_RD0,
        VIC_OP_RD1,
        VIC_OP_INIT,
        VIC_OP_EOS
    } vic_op_t;

    typedef struct packed {
        logic [13:0] rsvd_hi;
        logic [1:0] init_len;
        logic [7:0] data;
        logic [4:0] rsvd_lo;
        vic_op_t op;
    } vic_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic a0;
        logic ack_n;
        logic data_oe_n;
        logic [7:0] data;
    } vic_pins_t;

    typedef struct packed {
        logic rd;
        logic ack;
        logic a0;
        logic [7:0] data;
    } vic_item_t;

    typedef enum {ST_IDLE, ST_LOAD, ST_SETUP, ST_PULSE, ST_HOLD, ST_GAP} vic_state_t;

    typedef enum logic [1:0] {SEQ_CMD, SEQ_INIT, SEQ_ACK} vic_seq_t;

endpackage : vic_pkg

// *** tb/tb_vic_host.sv ***
// Purpose: self-checking bench for the interrupt controller host
// Assumes: device model on the pins, apb master tasks below
// Notes: status reads clear it, so each wait consumes the status
`timescale 1ns/1ps
`include "vic_params.svh"
module tb_vic_host
    import vic_pkg::*;
;
    logic i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, err;
    logic o_pready, o_pslverr, dev_int, o_irq, o_slave_program;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, q;
    logic [7:0] dev_data, i_data, o_request;
    logic [7:0] flip;
    vic_pins_t o_pins;
    int n_errors = 0;
    int num_checks = 0;

    // flip lets a scenario spoil the bytes the host reads back
    assign i_data = o_pins.data_oe_n ? (dev_data ^ flip) : o_pins.data;

    vic_host dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pins(o_pins),
        .i_data(i_data), .i_int(dev_int), .o_slave_program(o_slave_program),
        .o_request(o_request), .o_irq(o_irq));

    vic_dev_model dev_u (.i_pins(o_pins), .i_request(o_request),
        .i_slave_program(o_slave_program), .i_exp_id(3'h0), .o_data(dev_data),
        .o_int(dev_int), .o_exp_id());

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        @(posedge i_core_clk);
        while (o_pready !== 1'b1) @(posedge i_core_clk);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic get_status(input logic [31:0] exp);
        int n = 0;
        while (o_irq !== 1'b1 && n < 2000) begin
            @(posedge i_core_clk);
            n++;
        end
        apb(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk(q, exp);
    endtask : get_status

    task automatic cmd(input vic_op_t op, input logic [7:0] d, input logic [1:0] len);
        vic_cmd_t c;
        c = '{rsvd_hi: 14'h0, init_len: len, data: d, rsvd_lo: 5'h0, op: op};
        apb(1'b1, `VIC_OFF_CMD, c);
        get_status(32'h1);
    endtask : cmd

    task automatic int_level(input logic [31:0] req, input logic exp);
        apb(1'b1, `VIC_OFF_REQ, req);
        repeat (4) @(posedge i_core_clk);
        apb(1'b0, `VIC_OFF_STATE, 32'h0);
        chk(q[1], exp);
    endtask : int_level

    task automatic t_regs;
        int n = 0;
        apb(1'b0, `VIC_OFF_CTRL, 32'h0);
        chk(q, 32'h3);
        chk(o_slave_program, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, `VIC_OFF_CTRL, 32'h0);
        @(posedge i_core_clk);
        chk(o_slave_program, 1'b0);
        apb(1'b1, `VIC_OFF_CTRL, 32'h2);
        apb(1'b1, `VIC_OFF_MASK, 32'h0);
        apb(1'b1, `VIC_OFF_CMD, 32'h6);
        apb(1'b0, `VIC_OFF_STATE, 32'h0);
        chk(q[0], 1'b0);
        apb(1'b1, `VIC_OFF_INIT, 32'h0012b2);
        apb(1'b1, `VIC_OFF_CMD, 32'h00020004);
        do apb(1'b0, `VIC_OFF_STATE, 32'h0); while (q[0] !== 1'b0 && n++ < 200);
        chk(q[0], 1'b0);
        chk(o_irq, 1'b0);
        apb(1'b1, `VIC_OFF_MASK, 32'h3);
        @(posedge i_core_clk);
        chk(o_irq, 1'b1);
        get_status(32'h1);
    endtask : t_regs

    task automatic t_mask;
        cmd(VIC_OP_WR1, 8'h04, 2'h0);
        cmd(VIC_OP_RD1, 8'h00, 2'h0);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q & 32'hff, 32'h04);
        int_level(32'h04, 1'b0);
        int_level(32'h24, 1'b1);
        cmd(VIC_OP_INIT, 8'h00, 2'h2);
        cmd(VIC_OP_RD1, 8'h00, 2'h0);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q & 32'hff, 32'h00);
        int_level(32'h00, 1'b0);
        int_level(32'h24, 1'b1);
        cmd(VIC_OP_RD0, 8'h00, 2'h0);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q & 32'hff, 32'h24);
    endtask : t_mask

    task automatic t_ack;
        apb(1'b1, `VIC_OFF_CTRL, 32'h3);
        get_status(32'h2);
        chk(o_request, 32'h0);
        apb(1'b1, `VIC_OFF_CTRL, 32'h2);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q >> 8, 32'h0012a8cd);
        apb(1'b0, `VIC_OFF_STATE, 32'h0);
        chk(q[1], 1'b0);
        cmd(VIC_OP_WR0, 8'h0b, 2'h0);
        cmd(VIC_OP_RD0, 8'h00, 2'h0);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q & 32'hff, 32'h04);
        cmd(VIC_OP_EOS, 8'h00, 2'h0);
        apb(1'b1, `VIC_OFF_CTRL, 32'h3);
        get_status(32'h2);
        apb(1'b1, `VIC_OFF_CTRL, 32'h2);
        apb(1'b0, `VIC_OFF_RESULT, 32'h0);
        chk(q >> 8, 32'h0012b4cd);
        cmd(VIC_OP_EOS, 8'h00, 2'h0);
        int_level(32'h01, 1'b1);
        // spoiled opcode: host must give up after the first pulse
        flip <= 8'hff;
        apb(1'b1, `VIC_OFF_MASK, 32'h7);
        apb(1'b1, `VIC_OFF_CTRL, 32'h3);
        get_status(32'h4);
        chk(o_pins.ack_n, 1'b1);
    endtask : t_ack

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        i_rst_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        flip = 8'h00;
        repeat (12) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        t_regs;
        t_mask;
        t_ack;
        tally_and_finish;
    end

    // whole run is a few thousand cycles; this bound only cuts a hang
    initial begin
        repeat (30000) @(posedge i_core_clk);
        n_errors++;
        tally_and_finish;
    end
endmodule : tb_vic_host

// *** tb/vic_dev_model.sv ***
// Purpose: behavioural interrupt controller device behind the host pins
// Assumes: clockless, reacts to pin edges only
// Notes: vector interval four; a released bus shows the inverted last byte
`timescale 1ns/1ps
module vic_dev_model
    import vic_pkg::*;
(
    input wire vic_pins_t i_pins,
    input wire logic [7:0] i_request,
    input wire logic i_slave_program,
    input wire logic [2:0] i_exp_id,
    output logic [7:0] o_data,
    output logic o_int,
    output logic [2:0] o_exp_id
);
    logic [7:0] pending_request_bits = 8'h00, in_service_bits = 8'h00, mask_bits = 8'h00, prev = 8'h00;
    logic [7:0] w1 = 8'h00, w2 = 8'h00, w3 = 8'h00, val, last = 8'h00;
    logic [1:0] rsel = 2'h2;
    logic [3:0] win = 4'h0;
    logic drv;
    int step = 0;
    int ackn = 0;

    function automatic logic [3:0] top(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            if (v[i]) return 4'(i);
        end
        return 4'h8;
    endfunction : top

    // only a level above every one in service may interrupt
    assign o_int = top(pending_request_bits & ~mask_bits) < top(in_service_bits);
    // three id lines, eight slaves of eight levels each
    assign o_exp_id = i_slave_program ? win[2:0] : 3'bzzz;

    always @(i_request) begin
        pending_request_bits = pending_request_bits | (i_request & ~prev);
        prev = i_request;
    end

    always @(posedge i_pins.wr_n) begin
        if (!i_pins.cs_n && i_pins.rd_n) begin
            if (!i_pins.a0 && i_pins.data[4]) begin
                w1 = i_pins.data;
                mask_bits = 8'h00;
                pending_request_bits = 8'h00;
                // a line already high must fall and rise again to count
                prev = i_request;
                rsel = 2'h2;
                step = 1;
            end else if (!i_pins.a0 && i_pins.data[3]) begin
                if (i_pins.data[1]) rsel = i_pins.data[1:0];
            end else if (!i_pins.a0) begin
                if (in_service_bits != 8'h00) in_service_bits[top(in_service_bits)] = 1'b0;
            end else if (step == 1) begin
                w2 = i_pins.data;
                step = w1[1] ? 0 : 2;
            end else if (step == 2) begin
                w3 = i_pins.data;
                step = 0;
            end else begin
                mask_bits = i_pins.data;
            end
        end
    end

    always @(negedge i_pins.ack_n) begin
        ackn = ackn + 1;
        if (ackn == 1) begin
            win = top(pending_request_bits & ~mask_bits);
            in_service_bits[win] = 1'b1;
            pending_request_bits[win] = 1'b0;
        end
    end

    always @(posedge i_pins.ack_n) begin
        if (ackn == 3) ackn = 0;
    end

    always @* begin
        drv = 1'b0;
        val = 8'h00;
        if (!i_pins.cs_n && !i_pins.rd_n && i_pins.wr_n) begin
            drv = 1'b1;
            val = i_pins.a0 ? mask_bits : (rsel == 2'h3 ? in_service_bits : pending_request_bits);
        end else if (!i_pins.ack_n && ackn == 1) begin
            drv = 1'b1;
            val = 8'hcd;
        end else if (!i_pins.ack_n && ackn > 1 && (i_slave_program || w3[2:0] == i_exp_id)) begin
            drv = 1'b1;
            val = ackn == 2 ? {w1[7:5], win[2:0], 2'b00} : w2;
        end
        if (drv) last = val;
    end
    // a floating bus must not look like a held value
    assign o_data = drv ? val : ~last;
endmodule : vic_dev_model

// *** verilog/vic_host.sv ***
// Purpose: host that drives the interrupt controller pins from apb orders
// Assumes: device strobe timing met by cycle counts at 125 MHz
// Notes: apb answers with no wait state; one pin sequence at a time
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "vic_params.svh"
module vic_host
    import vic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output vic_pins_t o_pins,
    input wire logic [7:0] i_data,
    input wire logic i_int,
    output logic o_slave_program,
    output logic [7:0] o_request,
    output logic o_irq
);
    logic [1:0] rst_q_r;
    logic rst_n;
    logic [8:0] in_s;
    logic [7:0] data_s;
    logic int_s;
    vic_state_t state_r;
    vic_seq_t seq_r;
    logic [7:0] cnt_r;
    logic [1:0] idx_r;
    logic [1:0] len_r;
    vic_cmd_t cmd_r;
    vic_cmd_t cmd_w;
    vic_item_t item;
    vic_pins_t pins_r;
    logic [1:0] ctrl_r;
    logic [23:0] init_r;
    logic [7:0] rd_data_r;
    logic [23:0] ack_bytes_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [7:0] req_r;
    logic acc_wr;
    logic acc_rd;
    logic go_cmd;
    logic go_ack;
    logic cnt_end;
    logic pulse_end;
    logic seq_end;
    logic ev_bad;
    logic [2:0] ev;

    // reset released through two flops so every block leaves reset together
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_q_r <= 2'h0;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end
    assign rst_n = rst_q_r[1];

    vic_sync2 #(.W(9)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async({i_int, i_data}),
        .o_sync(in_s)
    );
    assign int_s = in_s[8];
    assign data_s = in_s[7:0];

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic [7:0] cyc(input int n);
        cyc = 8'(n - 1);
    endfunction : cyc

    // what the current step of the sequence puts on the pins
    function automatic vic_item_t item_of(input vic_seq_t s, input logic [1:0] i,
                                          input vic_cmd_t c, input logic [23:0] iw);
        item_of = '{rd: 1'b0, ack: 1'b0, a0: 1'b0, data: c.data};
        unique case (s)
            SEQ_INIT: begin
                item_of.a0 = (i != 2'h0);
                item_of.data = iw[i*8 +: 8];
                if (i == 2'h0) begin
                    item_of.data = iw[7:0] | `VIC_INIT1_FLAG;
                end
            end
            SEQ_ACK: begin
                item_of.rd = 1'b1;
                item_of.ack = 1'b1;
            end
            SEQ_CMD: begin
                item_of.rd = (c.op == VIC_OP_RD0) || (c.op == VIC_OP_RD1);
                item_of.a0 = (c.op == VIC_OP_WR1) || (c.op == VIC_OP_RD1);
                if (c.op == VIC_OP_EOS) begin
                    item_of.data = c.data & ~`VIC_WORD_SEL_BITS;
                end
            end
        endcase
    endfunction : item_of

    // acknowledge runs without chip select; strobes never overlap
    function automatic vic_pins_t pins_for(input vic_state_t st, input vic_item_t it);
        pins_for = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: it.a0, ack_n: 1'b1,
                     data_oe_n: 1'b1, data: it.data};
        if (st == ST_SETUP || st == ST_PULSE || st == ST_HOLD) begin
            pins_for.cs_n = it.ack;
            pins_for.data_oe_n = it.rd;
        end
        if (st == ST_PULSE) begin
            pins_for.wr_n = it.rd;
            pins_for.rd_n = !(it.rd && !it.ack);
            pins_for.ack_n = !it.ack;
        end
    endfunction : pins_for

    assign acc_wr = i_psel && i_penable && i_pwrite;
    assign acc_rd = i_psel && i_penable && !i_pwrite;
    assign cmd_w = vic_cmd_t'(i_pwdata);
    assign go_cmd = acc_wr && hit(i_paddr, `VIC_OFF_CMD) && state_r == ST_IDLE
                    && cmd_w.op <= VIC_OP_EOS;
    // answer the interrupt line with an acknowledge sequence
    assign go_ack = state_r == ST_IDLE && !go_cmd && int_s
                    && ctrl_r[`VIC_CTRL_AUTO_ACK];
    assign item = item_of(seq_r, idx_r, cmd_r, init_r);
    assign cnt_end = (cnt_r == 8'h0);
    assign pulse_end = state_r == ST_PULSE && cnt_end;
    assign seq_end = state_r == ST_GAP && cnt_end && (idx_r + 2'h1 == len_r);
    assign ev_bad = pulse_end && item.ack && idx_r == 2'h0 && data_s != `VIC_CALL_OPCODE;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            seq_r <= SEQ_CMD;
            cnt_r <= 8'h0;
            idx_r <= 2'h0;
            len_r <= 2'h1;
            cmd_r <= '0;
            pins_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: 1'b0, ack_n: 1'b1,
                        data_oe_n: 1'b1, data: 8'h0};
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    idx_r <= 2'h0;
                    if (go_cmd) begin
                        cmd_r <= cmd_w;
                        seq_r <= (cmd_w.op == VIC_OP_INIT) ? SEQ_INIT : SEQ_CMD;
                        len_r <= 2'h1;
                        if (cmd_w.op == VIC_OP_INIT) begin
                            // two words, or three for a cascaded array
                            len_r <= (cmd_w.init_len == `VIC_INIT_LONG) ?
                                     `VIC_INIT_LONG : `VIC_INIT_SHORT;
                        end
                        state_r <= ST_LOAD;
                    end else if (go_ack) begin
                        seq_r <= SEQ_ACK;
                        len_r <= `VIC_ACK_BYTES;
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    pins_r <= pins_for(ST_SETUP, item);
                    cnt_r <= cyc(`VIC_CYC_SETUP);
                    state_r <= ST_SETUP;
                end
                ST_SETUP: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_end) begin
                        pins_r <= pins_for(ST_PULSE, item);
                        cnt_r <= item.rd ? cyc(`VIC_CYC_RD) : cyc(`VIC_CYC_WR);
                        state_r <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_end) begin
                        pins_r <= pins_for(ST_HOLD, item);
                        cnt_r <= cyc(`VIC_CYC_HOLD);
                        state_r <= ST_HOLD;
                        // no call opcode: the two vector pulses are not issued
                        if (ev_bad) begin
                            len_r <= 2'h1;
                        end
                    end
                end
                ST_HOLD: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_end) begin
                        pins_r <= pins_for(ST_GAP, item);
                        cnt_r <= cyc(`VIC_CYC_GAP);
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_end) begin
                        idx_r <= idx_r + 2'h1;
                        state_r <= seq_end ? ST_IDLE : ST_LOAD;
                    end
                end
            endcase
        end
    end

    // sampled at the end of the pulse, well after the device data is valid
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h0;
            ack_bytes_r <= 24'h0;
        end else if (pulse_end && item.rd) begin
            if (item.ack) begin
                ack_bytes_r[idx_r*8 +: 8] <= data_s;
            end else begin
                rd_data_r <= data_s;
            end
        end
    end

    // request lines dropped only by a write to the request register or once the first acknowledge is over
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r <= 8'h0;
        end else if (acc_wr && hit(i_paddr, `VIC_OFF_REQ)) begin
            req_r <= i_pwdata[7:0];
        end else if (pulse_end && item.ack && idx_r == 2'h0) begin
            req_r <= 8'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `VIC_CTRL_RESET;
            init_r <= 24'h0;
            mask_r <= 3'h0;
        end else if (acc_wr) begin
            if (hit(i_paddr, `VIC_OFF_CTRL)) begin
                ctrl_r <= i_pwdata[1:0];
            end
            if (hit(i_paddr, `VIC_OFF_INIT)) begin
                init_r <= i_pwdata[23:0];
            end
            if (hit(i_paddr, `VIC_OFF_MASK)) begin
                mask_r <= i_pwdata[2:0];
            end
        end
    end

    always_comb begin
        ev = 3'h0;
        ev[`VIC_ST_CMD_DONE] = seq_end && seq_r != SEQ_ACK;
        ev[`VIC_ST_VEC_DONE] = seq_end && seq_r == SEQ_ACK && len_r == `VIC_ACK_BYTES;
        ev[`VIC_ST_BAD_OP] = ev_bad;
    end

    // a read clears the status, but an event in the same cycle survives
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 3'h0;
        end else if (acc_rd && hit(i_paddr, `VIC_OFF_STATUS)) begin
            status_r <= ev;
        end else begin
            status_r <= status_r | ev;
        end
    end

    always_comb begin
        o_prdata = 32'h0;
        o_pslverr = 1'b0;
        unique case (i_paddr)
            `VIC_OFF_CTRL: o_prdata[1:0] = ctrl_r;
            `VIC_OFF_CMD: o_prdata = cmd_r;
            `VIC_OFF_INIT: o_prdata[23:0] = init_r;
            `VIC_OFF_RESULT: o_prdata = {ack_bytes_r, rd_data_r};
            `VIC_OFF_STATUS: o_prdata[2:0] = status_r;
            `VIC_OFF_MASK: o_prdata[2:0] = mask_r;
            `VIC_OFF_REQ: o_prdata[7:0] = req_r;
            `VIC_OFF_STATE: o_prdata[1:0] = {int_s, state_r != ST_IDLE};
            default: o_pslverr = i_psel && i_penable;
        endcase
    end

    assign o_pready = 1'b1;
    assign o_pins = pins_r;
    assign o_request = req_r;
    // stays high for a lone controller unless software asks otherwise
    assign o_slave_program = ctrl_r[`VIC_CTRL_SLAVE_PROG];
    assign o_irq = |(status_r & mask_r);

    logic [1:0] ack_seen_r;
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_seen_r <= 2'h0;
        end else if (state_r == ST_IDLE) begin
            ack_seen_r <= 2'h0;
        end else if (pulse_end && item.ack) begin
            ack_seen_r <= ack_seen_r + 2'h1;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    chk_no_strobe_overlap: assert property (!(!o_pins.rd_n && !o_pins.wr_n))
        else $error("read and write strobes low together");
    chk_idle_pins_quiet: assert property (state_r == ST_IDLE |->
        o_pins.cs_n && o_pins.data_oe_n && o_pins.ack_n)
        else $error("pins active while idle");
    chk_three_acks: assert property (ev[`VIC_ST_VEC_DONE] |-> ack_seen_r == 2'h3)
        else $error("vector taken without three acknowledges");
    chk_bad_op_stops: assert property (ev_bad |=> o_pins.ack_n [*8])
        else $error("acknowledge continued after wrong opcode");
    chk_init_first_word: assert property (seq_r == SEQ_INIT && idx_r == 2'h0
        && !o_pins.wr_n |-> !o_pins.a0 && o_pins.data[4])
        else $error("init sequence not opened by word one");
    chk_init_length: assert property (state_r == ST_LOAD && seq_r == SEQ_INIT
        |-> len_r == 2'h2 || len_r == 2'h3)
        else $error("init sequence length wrong");
    chk_req_held: assert property ((|($past(o_request) & ~o_request))
        |-> $past(pulse_end && item.ack && idx_r == 2'h0) || $past(acc_wr))
        else $error("request dropped before first acknowledge");
    chk_eos_word: assert property (seq_r == SEQ_CMD && cmd_r.op == VIC_OP_EOS
        && !o_pins.wr_n |-> !o_pins.a0 && (o_pins.data & `VIC_WORD_SEL_BITS) == 8'h0)
        else $error("end of service not sent as word two");
    chk_slave_prog_reset: assert property ($rose(rst_n) |-> o_slave_program)
        else $error("slave program low after reset");
endmodule : vic_host

// *** verilog/vic_sync2.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to the core clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module vic_sync2 #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : vic_sync2
